//--- src/pcrg_top.sv
// Peripheral clock gating, AHB soft resets and debug clock freeze
`timescale 1ns/1ns
module pcrg_top #(
	parameter logic [31:0] CHIP_ID = pcrg_pkg::CHIP_ID_DEF
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pcrg_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [pcrg_pkg::DATA_W-1:0]   pwdata,
	output logic      [pcrg_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Core debug state, same clock domain
	input  wire logic                          debugHalt,
	// Controls to the peripheral clock and reset tree
	output pcrg_pkg::pcrg_ctl_t                ctl
);

	logic [pcrg_pkg::AHB_N-1:0] ahbPeriphReset;
	logic [pcrg_pkg::APB_N-1:0] apbClockGate;
	logic [pcrg_pkg::AHB_N-1:0] ahbClockGate;
	logic [pcrg_pkg::APB_N-1:0] apbDebugFreeze;
	logic [pcrg_pkg::APB_N-1:0] next_apbClkRun;
	logic [pcrg_pkg::APB_N-1:0] apbRunLevel;
	logic                       setupPhase;
	logic                       accessPhase;
	logic                       wrDone;

	// Address decode for the error answer; the read mux decodes paddr on its own
	function automatic logic isMapped(
		input logic [pcrg_pkg::ADDR_W-1:0] addr
	);
		isMapped = (addr == pcrg_pkg::OFF_AHB_RST)  ||
		           (addr == pcrg_pkg::OFF_APB_GATE) ||
		           (addr == pcrg_pkg::OFF_AHB_GATE) ||
		           (addr == pcrg_pkg::OFF_FREEZE)   ||
		           (addr == pcrg_pkg::OFF_CHIP_ID);
	endfunction : isMapped

	function automatic logic wrHit(
		input logic                        done,
		input logic [pcrg_pkg::ADDR_W-1:0] addr,
		input logic [pcrg_pkg::ADDR_W-1:0] off
	);
		wrHit = done && (addr == off);
	endfunction : wrHit

	// Zero wait states keep the core path short
	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;
	assign wrDone      = accessPhase && pwrite;
	assign pready      = 1'b1;
	assign pslverr     = accessPhase && !isMapped(paddr);

	// AHB soft resets
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ahbPeriphReset <= pcrg_pkg::AHB_RST_VAL;
		end else if (wrHit(wrDone, paddr, pcrg_pkg::OFF_AHB_RST)) begin
			ahbPeriphReset <= pwdata[pcrg_pkg::AHB_N-1:0];
		end
	end

	// APB clock gates
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			apbClockGate <= pcrg_pkg::APB_RST_VAL;
		end else if (wrHit(wrDone, paddr, pcrg_pkg::OFF_APB_GATE)) begin
			apbClockGate <= pwdata[pcrg_pkg::APB_N-1:0];
		end
	end

	// AHB clock gates
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ahbClockGate <= pcrg_pkg::AHB_RST_VAL;
		end else if (wrHit(wrDone, paddr, pcrg_pkg::OFF_AHB_GATE)) begin
			ahbClockGate <= pwdata[pcrg_pkg::AHB_N-1:0];
		end
	end

	// Freeze bits exist only where a freeze is wired; others stay zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			apbDebugFreeze <= pcrg_pkg::APB_RST_VAL;
		end else if (wrHit(wrDone, paddr, pcrg_pkg::OFF_FREEZE)) begin
			apbDebugFreeze <= pwdata[pcrg_pkg::APB_N-1:0]
			                  & pcrg_pkg::FREEZE_MASK;
		end
	end

	// Debug freeze overrides the gate only while halted
	always_comb begin
		next_apbClkRun = apbClockGate;
		if (debugHalt) begin
			next_apbClkRun = apbClockGate & ~apbDebugFreeze;
		end
	end

	// Registered run levels feed glitch-free gate cells downstream
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			apbRunLevel <= pcrg_pkg::APB_RST_VAL;
		end else begin
			apbRunLevel <= next_apbClkRun;
		end
	end

	// One driver for the whole bundle keeps the struct single-sourced
	assign ctl = '{
		apbClkRun: apbRunLevel,
		ahbClkRun: ahbClockGate,
		ahbRst:    ahbPeriphReset
	};

	// Read data captured in setup so it stands for the whole access
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= pcrg_pkg::ZERO_WORD;
		end else if (setupPhase && !pwrite) begin
			unique case (paddr)
				pcrg_pkg::OFF_AHB_RST:
					prdata <= {{(pcrg_pkg::DATA_W-pcrg_pkg::AHB_N){1'b0}},
					           ahbPeriphReset};
				pcrg_pkg::OFF_APB_GATE:
					prdata <= {{(pcrg_pkg::DATA_W-pcrg_pkg::APB_N){1'b0}},
					           apbClockGate};
				pcrg_pkg::OFF_AHB_GATE:
					prdata <= {{(pcrg_pkg::DATA_W-pcrg_pkg::AHB_N){1'b0}},
					           ahbClockGate};
				pcrg_pkg::OFF_FREEZE:
					prdata <= {{(pcrg_pkg::DATA_W-pcrg_pkg::APB_N){1'b0}},
					           apbDebugFreeze};
				pcrg_pkg::OFF_CHIP_ID:
					prdata <= CHIP_ID;
				default:
					prdata <= pcrg_pkg::ZERO_WORD;
			endcase
		end
	end

	// Checks
	default clocking cbClk @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_ahbRstWrite;
		wrDone && paddr == pcrg_pkg::OFF_AHB_RST
		|=> ctl.ahbRst == $past(pwdata[pcrg_pkg::AHB_N-1:0]);
	endproperty
	a_ahbRstWrite: assert property (p_ahbRstWrite)
		else $error("AHB reset output does not follow write");

	property p_apbGateMap;
		wrDone && paddr == pcrg_pkg::OFF_APB_GATE && !debugHalt
		##1 !debugHalt
		|=> ctl.apbClkRun == $past(pwdata[pcrg_pkg::APB_N-1:0], 2);
	endproperty
	a_apbGateMap: assert property (p_apbGateMap)
		else $error("APB run bits not in written positions");

	property p_apbRunNoHalt;
		!debugHalt |=> ctl.apbClkRun == $past(apbClockGate);
	endproperty
	a_apbRunNoHalt: assert property (p_apbRunNoHalt)
		else $error("APB clock run differs from gate outside debug");

	property p_ahbGateWrite;
		wrDone && paddr == pcrg_pkg::OFF_AHB_GATE
		|=> ctl.ahbClkRun == $past(pwdata[pcrg_pkg::AHB_N-1:0]);
	endproperty
	a_ahbGateWrite: assert property (p_ahbGateWrite)
		else $error("AHB clock run does not follow write");

	property p_freezeStops;
		debugHalt |=> (ctl.apbClkRun & $past(apbDebugFreeze)) == '0;
	endproperty
	a_freezeStops: assert property (p_freezeStops)
		else $error("Frozen APB clock still runs in debug");

	property p_freezeOnlyMask;
		debugHalt |=> (ctl.apbClkRun & ~pcrg_pkg::FREEZE_MASK)
		              == ($past(apbClockGate) & ~pcrg_pkg::FREEZE_MASK);
	endproperty
	a_freezeOnlyMask: assert property (p_freezeOnlyMask)
		else $error("Freeze affected an unsupported position");

	property p_chipIdRead;
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_CHIP_ID
		|-> prdata == CHIP_ID && !pslverr && pready;
	endproperty
	a_chipIdRead: assert property (p_chipIdRead)
		else $error("Chip identifier read wrong");

	property p_unusedZero;
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_AHB_RST
		|-> prdata[pcrg_pkg::DATA_W-1:pcrg_pkg::AHB_N] == '0;
	endproperty
	a_unusedZero: assert property (p_unusedZero)
		else $error("Unassigned reset bits not zero");

	property p_freezeStore;
		wrDone && paddr == pcrg_pkg::OFF_FREEZE
		|=> (apbDebugFreeze & ~pcrg_pkg::FREEZE_MASK) == '0;
	endproperty
	a_freezeStore: assert property (p_freezeStore)
		else $error("Freeze bit stored at unsupported position");

	// Control bits move only on their own write; a stray decode would
	// otherwise flip another peripheral's clock or reset silently
	property p_ahbRstHold;
		!(wrDone && paddr == pcrg_pkg::OFF_AHB_RST)
		|=> $stable(ctl.ahbRst);
	endproperty
	a_ahbRstHold: assert property (p_ahbRstHold)
		else $error("AHB reset changed without a write");

	property p_apbGateHold;
		!(wrDone && paddr == pcrg_pkg::OFF_APB_GATE)
		|=> $stable(apbClockGate);
	endproperty
	a_apbGateHold: assert property (p_apbGateHold)
		else $error("APB clock gate changed without a write");

	property p_ahbGateHold;
		!(wrDone && paddr == pcrg_pkg::OFF_AHB_GATE)
		|=> $stable(ctl.ahbClkRun);
	endproperty
	a_ahbGateHold: assert property (p_ahbGateHold)
		else $error("AHB clock run changed without a write");

	property p_freezeHold;
		!(wrDone && paddr == pcrg_pkg::OFF_FREEZE)
		|=> $stable(apbDebugFreeze);
	endproperty
	a_freezeHold: assert property (p_freezeHold)
		else $error("Freeze bits changed without a write");

	property p_apbGateRead;
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_APB_GATE
		|-> prdata[pcrg_pkg::APB_N-1:0] == apbClockGate
		    && prdata[pcrg_pkg::DATA_W-1:pcrg_pkg::APB_N] == '0;
	endproperty
	a_apbGateRead: assert property (p_apbGateRead)
		else $error("APB clock gate read back wrong");

	property p_ahbGateRead;
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_AHB_GATE
		|-> prdata[pcrg_pkg::AHB_N-1:0] == ahbClockGate
		    && prdata[pcrg_pkg::DATA_W-1:pcrg_pkg::AHB_N] == '0;
	endproperty
	a_ahbGateRead: assert property (p_ahbGateRead)
		else $error("AHB clock gate read back wrong");

	property p_freezeRead;
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_FREEZE
		|-> (prdata[pcrg_pkg::APB_N-1:0] & ~pcrg_pkg::FREEZE_MASK) == '0
		    && prdata[pcrg_pkg::DATA_W-1:pcrg_pkg::APB_N] == '0;
	endproperty
	a_freezeRead: assert property (p_freezeRead)
		else $error("Freeze read shows unsupported position");

	property p_chipIdNoError;
		accessPhase && paddr == pcrg_pkg::OFF_CHIP_ID |-> !pslverr;
	endproperty
	a_chipIdNoError: assert property (p_chipIdNoError)
		else $error("Chip identifier access answered an error");

	property p_unmappedReadZero;
		accessPhase && !pwrite && pslverr |-> prdata == pcrg_pkg::ZERO_WORD;
	endproperty
	a_unmappedReadZero: assert property (p_unmappedReadZero)
		else $error("Unmapped read returned nonzero data");

	// An error outside the access phase would confuse the core's bus logic
	property p_errorOnlyInAccess;
		!accessPhase |-> !pslverr;
	endproperty
	a_errorOnlyInAccess: assert property (p_errorOnlyInAccess)
		else $error("Error response outside access phase");

	c_freezeInDebug: cover property (
		debugHalt && apbDebugFreeze != '0 && apbClockGate != '0);
	c_chipIdRead: cover property (
		accessPhase && !pwrite && paddr == pcrg_pkg::OFF_CHIP_ID);
	c_ahbReset: cover property (
		wrDone && paddr == pcrg_pkg::OFF_AHB_RST && pwdata[0]);
	c_badAddr: cover property (pslverr);

endmodule : pcrg_top

//--- src/pcrg_pkg.sv
// Constants and types for peripheral clock and reset gating
package pcrg_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int APB_N  = 29;
	localparam int AHB_N  = 4;

	// Byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFF_AHB_RST  = 12'h050;
	localparam logic [ADDR_W-1:0] OFF_APB_GATE = 12'h060;
	localparam logic [ADDR_W-1:0] OFF_AHB_GATE = 12'h070;
	localparam logic [ADDR_W-1:0] OFF_FREEZE   = 12'h080;
	localparam logic [ADDR_W-1:0] OFF_CHIP_ID  = 12'h100;

	// AHB slot positions
	localparam int SLOT_DMA = 0;
	localparam int SLOT_USB = 1;
	localparam int SLOT_CRC = 2;
	localparam int SLOT_ETH = 3;

	// APB positions that may be frozen: watchdog, two timers,
	// five general purpose timers and CAN
	localparam logic [APB_N-1:0] FREEZE_MASK = 29'h041F_C002;

	// Reset values
	localparam logic [APB_N-1:0] APB_RST_VAL = 29'h0000_0000;
	localparam logic [AHB_N-1:0] AHB_RST_VAL = 4'h0;
	localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

	// Arbitrary identifier value, not tied to any real part
	localparam logic [DATA_W-1:0] CHIP_ID_DEF = 32'h5A5A_0001;

	// Per-peripheral controls handed to the clock and reset tree
	typedef struct packed {
		logic [APB_N-1:0] apbClkRun;
		logic [AHB_N-1:0] ahbClkRun;
		logic [AHB_N-1:0] ahbRst;
	} pcrg_ctl_t;

endpackage : pcrg_pkg

//--- test/pcrg_periph_model.sv
// Gated peripheral stand-in that only advances while its clock runs
`timescale 1ns/1ns
module pcrg_periph_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Clock run level from the gating block
	input  wire logic       run,
	// Cycles the peripheral has seen
	output logic      [7:0] ticks
);
	// A stopped clock must freeze the count, so any stray run shows up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ticks <= 8'h00;
		end else if (run) begin
			ticks <= ticks + 8'h01;
		end
	end
endmodule : pcrg_periph_model

//--- test/tb_top.sv
// Self-checking bench for the peripheral clock and reset gating block
`timescale 1ns/1ns
module tb_top;
	logic                clk, nrst, psel, penable, pwrite, debugHalt;
	logic                pready, pslverr, er;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [7:0]          wdTicks, fbTicks, a, b;
	pcrg_pkg::pcrg_ctl_t ctl;
	int                  errCount, testsRun;
	// Arbitrary identifier value
	localparam logic [31:0] ID = 32'h1234_ABCD;
	pcrg_top #(.CHIP_ID(ID)) i_pcrg_top (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .debugHalt(debugHalt), .ctl(ctl));
	pcrg_periph_model i_pcrg_periph_model (.clk(clk), .nrst(nrst),
		.run(ctl.apbClkRun[1]), .ticks(wdTicks));
	pcrg_periph_model i_pcrg_periph_model_b (.clk(clk), .nrst(nrst),
		.run(ctl.apbClkRun[0]), .ticks(fbTicks));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic completeRun();
		$display("checks %0d errors %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : completeRun
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: %s %h", $time, m, got);
		end
	endtask : chk
	// One APB transfer; waits for pready under a bound
	task automatic xfer(input logic w, input logic [11:0] ad,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			errCount++;
			completeRun();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// Let the registered clock run levels settle
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask : settle
	task automatic chkCtl(input logic [28:0] ap, input logic [7:0] ah);
		chk({3'h0, ctl.apbClkRun}, {3'h0, ap}, "apb run");
		chk({24'h0, ctl.ahbClkRun, ctl.ahbRst}, {24'h0, ah}, "ahb");
	endtask : chkCtl
	task automatic tResetValues();
		chkCtl(29'h0000_0000, 8'h00);
		for (int i = 5; i <= 8; i++) begin
			xfer(1'b0, 12'(i * 16), 32'h0000_0000);
			chk(rd, 32'h0000_0000, "reset value");
		end
	endtask : tResetValues
	task automatic tRegisters();
		logic [31:0] exp [4] = '{32'h0000_000F, 32'h1FFF_FFFF,
			32'h0000_000F, 32'h041F_C002};
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, 12'(80 + i * 16), 32'hFFFF_FFFF);
			xfer(1'b0, 12'(80 + i * 16), 32'h0000_0000);
			chk(rd, exp[i], "register width");
		end
		settle();
		chkCtl(29'h1FFF_FFFF, 8'hFF);
		xfer(1'b1, 12'h050, 32'h0000_0005);
		settle();
		chkCtl(29'h1FFF_FFFF, 8'hF5);
	endtask : tRegisters
	// Watchdog slot freezes in debug, fabric slot keeps running
	task automatic tFreeze();
		debugHalt <= 1'b1;
		settle();
		chkCtl(29'h1BE0_3FFD, 8'hF5);
		a = wdTicks;
		b = fbTicks;
		repeat (4) @(posedge clk);
		chk({24'h0, wdTicks}, {24'h0, a}, "frozen");
		chk({24'h0, fbTicks}, {24'h0, b + 8'h04}, "running");
		debugHalt <= 1'b0;
		settle();
		chkCtl(29'h1FFF_FFFF, 8'hF5);
	endtask : tFreeze
	task automatic tIdentifier();
		xfer(1'b1, 12'h100, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0000, "identifier error");
		xfer(1'b0, 12'h100, 32'h0000_0000);
		chk(rd, ID, "identifier");
	endtask : tIdentifier
	// Unmapped offset answers an error, keeps nothing
	task automatic tUnmapped();
		xfer(1'b1, 12'h040, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h0000_0001, "write error");
		xfer(1'b0, 12'h040, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped data");
	endtask : tUnmapped
	task automatic tReset();
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		chkCtl(29'h0000_0000, 8'h00);
		nrst <= 1'b1;
		xfer(1'b0, 12'h060, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "gate after reset");
	endtask : tReset
	initial begin
		{nrst, psel, penable, pwrite, debugHalt} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		errCount = 0;
		testsRun = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		tResetValues();
		tRegisters();
		tFreeze();
		tIdentifier();
		tUnmapped();
		tReset();
		completeRun();
	end
endmodule : tb_top
